// [hdl/rsw_top.sv]
// Reset controller with cause flags and watchdog, AXI4-Lite register port.
// Assumes every input is synchronous to aclk; aresetn is the power-on reset.
//
// Functional notes
// - Reset halts core, presets registers and pins, stops irqs, timers.
// - Port latches are all ones during and after reset.
// - Data memory is kept; only the stack pointer is reloaded.
// - On exit: PC zero, slowest clock, fetch from zero once stable.
// - Any system reset leaves the watchdog running at longest interval.
// - Supply reset drives the reset pin low through the long timeout.
// - Supply monitor counts only if its pin and power-on bit enable it, or its pin alone during power-up.
// - Power-on exit sets power-on flag; any other reset clears it.
// - Supply dip drives the pin low, resets, and exits like power-on.
// - Low reset pin resets; reset lasts twelve cycles after release.
// - Pin reset exit sets bit 0 of the cause register.
// - Clock loss resets, sets its flag, and leaves the pin alone.
// - Bit 2 written one enables clock loss as a reset source.
// - Bit 5 enables comparator reset while plus input is below minus.
// - Comparator reset sets its flag and leaves the reset pin alone.
// - Bit 6 makes conversion start an active-low level reset source.
// - Such input starts no conversion; its reset sets its flag only.
// - Watchdog overflow resets the system without touching the pin.
// - Watchdog is a 21-bit counter timing the gap between kicks.
// - Writing A5 enables the watchdog and restarts it from zero.
// - Watchdog disables only on DE then AD within four cycles.
// - Writing FF locks out disabling until the next system reset.
// - Timeout is 4 to the power 3 plus interval; interval resets to 7.
// - Interval field updates only when written bit 7 is zero.
// - Control register bit 4 reads one while the watchdog runs.
//
// Our own choices: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
module rsw_top #(
  parameter int unsigned MON_HOLD_CYCLES = rsw_pkg::MON_HOLD_CYCLES
) (
  input  wire logic                       aclk,
  input  wire logic                       aresetn,
  input  wire logic [rsw_pkg::ADDR_W-1:0] awaddr,
  input  wire logic                       awvalid,
  output logic                            awready,
  input  wire logic [31:0]                wdata,
  input  wire logic [3:0]                 wstrb,
  input  wire logic                       wvalid,
  output logic                            wready,
  output logic [1:0]                      bresp,
  output logic                            bvalid,
  input  wire logic                       bready,
  input  wire logic [rsw_pkg::ADDR_W-1:0] araddr,
  input  wire logic                       arvalid,
  output logic                            arready,
  output logic [31:0]                     rdata,
  output logic [1:0]                      rresp,
  output logic                            rvalid,
  input  wire logic                       rready,
  input  wire logic                       supply_low,
  input  wire logic                       supply_monitor_en_pin,
  input  wire logic                       rst_pin_in,
  output logic                            rst_pin_out,
  output logic                            rst_pin_oe,
  input  wire logic                       conversion_start_input,
  input  wire logic                       cmp_plus_above_minus,
  input  wire logic                       clock_loss_detected,
  input  wire logic                       clock_stable,
  output logic                            adc_convstart,
  output logic                            sys_reset_n,
  output logic                            core_halt,
  output logic                            port_latch_load,
  output logic [7:0]                      port_latch_value,
  output logic                            stack_ptr_reload,
  output logic                            irq_timer_disable,
  output logic                            osc_lowest_select,
  output logic                            fetch_enable,
  output logic [15:0]                     fetch_address
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic                      aw_held, w_held, wr_fire;
  logic [rsw_pkg::ADDR_W-1:0] wr_addr;
  logic [7:0]                wr_byte;
  logic                      wr_lane;
  logic                      wr_cause, wr_wdog;
  logic                      por_start, in_reset, in_reset_q, reset_exit;
  logic                      short_active, mon_active;
  logic                      mon_src, pin_src, clk_src, cmp_src, cnv_src;
  logic                      acc_por, acc_pin, acc_clk, acc_cmp;
  logic                      acc_cnv, acc_wdt;
  logic                      power_on_flag, pin_reset_flag, clock_loss_flag;
  logic                      wdt_flag, cmp_flag, cnv_flag;
  logic                      clk_loss_en, comparator_reset_en_flag;
  logic                      convstart_reset_en_flag;
  logic                      wdt_active, wdt_locked, wdt_overflow;
  logic                      disable_ok;
  logic [2:0]                wdt_interval;
  logic [rsw_pkg::WD_W-1:0]  watchdog_counter;

  // Decodes a register address; returns 1 for cause, 2 for watchdog.
  function automatic logic [1:0] reg_sel(
    input logic [rsw_pkg::ADDR_W-1:0] a);
    if (a == rsw_pkg::ADDR_CAUSE) begin
      return 2'h1;
    end else if (a == rsw_pkg::ADDR_WDOG) begin
      return 2'h2;
    end
    return 2'h0;
  endfunction : reg_sel

  // ****************************************************************
  // AXI4-Lite slave
  // ****************************************************************
  // Address and data are taken in either order and held until both exist.
  assign awready = !aw_held && !bvalid;
  assign wready  = !w_held && !bvalid;
  assign arready = !rvalid;
  assign wr_fire = aw_held && w_held;
  assign wr_cause = wr_fire && wr_lane && (reg_sel(wr_addr) == 2'h1);
  assign wr_wdog  = wr_fire && wr_lane && (reg_sel(wr_addr) == 2'h2);

  // Write channel capture.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      wr_addr <= '0;
      wr_byte <= 8'h00;
      wr_lane <= 1'b0;
    end else begin
      if (awvalid && awready) begin
        aw_held <= 1'b1;
        wr_addr <= awaddr;
      end else if (wr_fire) begin
        aw_held <= 1'b0;
      end
      if (wvalid && wready) begin
        w_held  <= 1'b1;
        wr_byte <= wdata[7:0];
        wr_lane <= wstrb[0];
      end else if (wr_fire) begin
        w_held <= 1'b0;
      end
    end
  end

  // Write response; unmapped addresses answer SLVERR and change nothing.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp  <= rsw_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      bvalid <= 1'b1;
      bresp  <= (reg_sel(wr_addr) != 2'h0) ? rsw_pkg::RESP_OKAY
                                            : rsw_pkg::RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // Read channel; upper bits of each word read as zero.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata  <= 32'h0000_0000;
      rresp  <= rsw_pkg::RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rdata  <= 32'h0000_0000;
      rresp  <= rsw_pkg::RESP_OKAY;
      unique case (reg_sel(araddr))
        2'h1: begin
          rdata[rsw_pkg::PIN_BIT] <= pin_reset_flag;
          rdata[rsw_pkg::POR_BIT] <= power_on_flag;
          rdata[rsw_pkg::CLK_BIT] <= clock_loss_flag;
          rdata[rsw_pkg::WDT_BIT] <= wdt_flag;
          rdata[rsw_pkg::CMP_BIT] <= cmp_flag;
          rdata[rsw_pkg::CNV_BIT] <= cnv_flag;
        end
        2'h2: begin
          rdata[2:0]                  <= wdt_interval;
          rdata[rsw_pkg::WD_STAT_BIT] <= wdt_active;
        end
        default: begin
          rresp <= rsw_pkg::RESP_SLVERR;
        end
      endcase
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

  // ****************************************************************
  // Reset sources and merging
  // ****************************************************************
  // The monitor stays armed during the power-up phase via acc_por.
  assign mon_src = supply_monitor_en_pin && supply_low
                   && (power_on_flag || acc_por);
  // The pin is ignored while this block drives it low itself.
  assign pin_src = !rst_pin_in && !rst_pin_oe && !mon_active;
  assign clk_src = clk_loss_en && clock_loss_detected;
  assign cmp_src = comparator_reset_en_flag
                   && !cmp_plus_above_minus;
  assign cnv_src = convstart_reset_en_flag
                   && !conversion_start_input;

  // Power-up runs the long supply timeout once after aresetn releases.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      por_start <= 1'b1;
    end else begin
      por_start <= 1'b0;
    end
  end

  rsw_stretch #(
    .HOLD    (MON_HOLD_CYCLES)
  ) u_mon_hold (
    .aclk    (aclk),
    .aresetn (aresetn),
    .trigger (mon_src || por_start),
    .active  (mon_active)
  );

  rsw_stretch #(
    .HOLD    (rsw_pkg::PIN_HOLD)
  ) u_pin_hold (
    .aclk    (aclk),
    .aresetn (aresetn),
    .trigger (pin_src || clk_src || cmp_src || cnv_src || wdt_overflow),
    .active  (short_active)
  );

  assign in_reset   = mon_active || short_active;
  assign reset_exit = in_reset_q && !in_reset;

  // Gather every source seen during one reset episode.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      in_reset_q <= 1'b1;
      {acc_pin, acc_clk, acc_cmp, acc_cnv, acc_wdt} <= 5'h00;
      acc_por <= 1'b1;
    end else begin
      in_reset_q <= in_reset;
      if (in_reset) begin
        acc_por <= acc_por || mon_src;
        acc_pin <= acc_pin || pin_src;
        acc_clk <= acc_clk || clk_src;
        acc_cmp <= acc_cmp || cmp_src;
        acc_cnv <= acc_cnv || cnv_src;
        acc_wdt <= acc_wdt || wdt_overflow;
      end else begin
        {acc_por, acc_pin, acc_clk, acc_cmp, acc_cnv, acc_wdt} <= 6'h00;
      end
    end
  end

  // Cause flags latch at release; the hardware update beats a bus write.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      power_on_flag <= 1'b0;
      {pin_reset_flag, clock_loss_flag, wdt_flag} <= 3'h0;
      {cmp_flag, cnv_flag} <= 2'h0;
    end else if (reset_exit) begin
      power_on_flag   <= acc_por;
      pin_reset_flag  <= acc_pin && !acc_por;
      clock_loss_flag <= acc_clk && !acc_por;
      wdt_flag        <= acc_wdt && !acc_por;
      cmp_flag        <= acc_cmp && !acc_por;
      cnv_flag        <= acc_cnv && !acc_por;
    end else if (wr_cause) begin
      power_on_flag <= wr_byte[rsw_pkg::POR_BIT];
    end
  end

  // Source enables survive a system reset so a level source keeps holding.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      clk_loss_en              <= 1'b0;
      comparator_reset_en_flag <= 1'b0;
      convstart_reset_en_flag  <= 1'b0;
    end else if (wr_cause) begin
      clk_loss_en              <= wr_byte[rsw_pkg::CLK_BIT];
      comparator_reset_en_flag <= wr_byte[rsw_pkg::CMP_BIT];
      convstart_reset_en_flag  <= wr_byte[rsw_pkg::CNV_BIT];
    end
  end

  // ****************************************************************
  // Watchdog
  // ****************************************************************
  rsw_disarm u_disarm (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .clear      (in_reset),
    .wr_strobe  (wr_wdog),
    .wr_data    (wr_byte),
    .disable_ok (disable_ok)
  );

  // Not gated by in_reset, which would loop back through the stretcher.
  assign wdt_overflow = wdt_active
    && (watchdog_counter == rsw_pkg::wd_limit(wdt_interval));

  // Control state; every system reset restarts it at the longest interval.
  always_ff @(posedge aclk) begin
    if (!aresetn || in_reset) begin
      wdt_active   <= 1'b1;
      wdt_locked   <= 1'b0;
      wdt_interval <= rsw_pkg::WD_IVL_RST;
    end else if (wr_wdog) begin
      if (wr_byte == rsw_pkg::WD_KICK) begin
        wdt_active <= 1'b1;
      end else if (wr_byte == rsw_pkg::WD_LOCK) begin
        wdt_locked <= 1'b1;
      end else if (disable_ok && !wdt_locked) begin
        wdt_active <= 1'b0;
      end else if (!wr_byte[rsw_pkg::WD_GUARD_BIT]) begin
        wdt_interval <= wr_byte[2:0];
      end
    end
  end

  // The 21-bit count restarts on every kick and on every system reset.
  always_ff @(posedge aclk) begin
    if (!aresetn || in_reset) begin
      watchdog_counter <= '0;
    end else if (wr_wdog && (wr_byte == rsw_pkg::WD_KICK)) begin
      watchdog_counter <= '0;
    end else if (wdt_active) begin
      watchdog_counter <= watchdog_counter + 21'h1;
    end
  end

  // ****************************************************************
  // Reset state outputs
  // ****************************************************************
  // All registered so the core sees clean levels; the pin only drives low.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sys_reset_n       <= 1'b0;
      core_halt         <= 1'b1;
      port_latch_load   <= 1'b1;
      port_latch_value  <= rsw_pkg::PORT_RESET_VAL;
      stack_ptr_reload  <= 1'b1;
      irq_timer_disable <= 1'b1;
      osc_lowest_select <= 1'b1;
      fetch_enable      <= 1'b0;
      fetch_address     <= rsw_pkg::RESET_VECTOR;
      rst_pin_out       <= 1'b0;
      rst_pin_oe        <= 1'b0;
      adc_convstart     <= 1'b1;
    end else begin
      sys_reset_n       <= !in_reset;
      core_halt         <= in_reset || !fetch_enable;
      port_latch_load   <= in_reset;
      port_latch_value  <= rsw_pkg::PORT_RESET_VAL;
      stack_ptr_reload  <= in_reset;
      irq_timer_disable <= in_reset;
      osc_lowest_select <= in_reset;
      fetch_enable      <= !in_reset && (fetch_enable || clock_stable);
      fetch_address     <= rsw_pkg::RESET_VECTOR;
      rst_pin_out       <= 1'b0;
      rst_pin_oe        <= mon_active;
      adc_convstart     <= convstart_reset_en_flag ? 1'b1
                           : conversion_start_input;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_pin_released;
    $rose(rst_pin_in) && $past(pin_src) && !mon_active && !clk_src
    && !cmp_src && !cnv_src;
  endsequence

  a_pin_hold_twelve: assert property (
    s_pin_released |-> in_reset ##11 in_reset)
    else $error("reset ended early after pin release");

  a_por_flag_set: assert property (
    reset_exit && acc_por |=> power_on_flag && !pin_reset_flag)
    else $error("power-on flag wrong after power-on exit");

  a_pin_flag_set: assert property (
    reset_exit && acc_pin && !acc_por |=> pin_reset_flag && !power_on_flag)
    else $error("pin flag wrong after pin reset exit");

  a_wdt_reset_state: assert property (
    $fell(in_reset) |-> wdt_active && wdt_interval == rsw_pkg::WD_IVL_RST
                        && watchdog_counter == '0)
    else $error("watchdog not at default after reset");

  a_wdt_kick_restart: assert property (
    wr_wdog && wr_byte == rsw_pkg::WD_KICK && !in_reset
    |=> wdt_active && watchdog_counter == '0)
    else $error("kick did not restart watchdog");

  a_wdt_overflow_rst: assert property (
    wdt_overflow |-> in_reset ##1 (in_reset && !rst_pin_oe))
    else $error("overflow did not reset quietly");

  a_wdt_lock_keeps: assert property (
    wdt_locked && wdt_active && !in_reset |=> wdt_active)
    else $error("locked watchdog was disabled");

  a_wdt_disable_src: assert property (
    $fell(wdt_active) |-> $past(disable_ok) && !$past(wdt_locked))
    else $error("watchdog stopped without valid sequence");

  a_pin_drive_mon: assert property (
    rst_pin_oe |-> $past(mon_active) && !rst_pin_out)
    else $error("reset pin driven outside supply timeout");

  a_ports_ones: assert property (
    in_reset |=> port_latch_load
                 && port_latch_value == rsw_pkg::PORT_RESET_VAL)
    else $error("port latches not preset in reset");

  a_cnv_blocked: assert property (
    convstart_reset_en_flag |=> adc_convstart)
    else $error("conversion start passed while a reset source");

endmodule : rsw_top

// [pkg/rsw_pkg.sv]
// Constants shared by the reset source and watchdog block.
// Assumes a 250 MHz system clock and a 32-bit AXI4-Lite register port.
package rsw_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam int unsigned ADDR_W     = 8;
  localparam logic [7:0]  ADDR_CAUSE = 8'h00;
  localparam logic [7:0]  ADDR_WDOG  = 8'h04;
  localparam logic [1:0]  RESP_OKAY  = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // Bit positions in reset_cause_reg.
  localparam int unsigned PIN_BIT = 0;
  localparam int unsigned POR_BIT = 1;
  localparam int unsigned CLK_BIT = 2;
  localparam int unsigned WDT_BIT = 3;
  localparam int unsigned CMP_BIT = 5;
  localparam int unsigned CNV_BIT = 6;

  // Bit positions in watchdog_control_reg.
  localparam int unsigned WD_STAT_BIT  = 4;
  localparam int unsigned WD_GUARD_BIT = 7;

  // ****************************************************************
  // Watchdog commands and timing
  // ****************************************************************
  localparam logic [7:0]  WD_KICK    = 8'hA5;
  localparam logic [7:0]  WD_DIS1    = 8'hDE;
  localparam logic [7:0]  WD_DIS2    = 8'hAD;
  localparam logic [7:0]  WD_LOCK    = 8'hFF;
  localparam logic [2:0]  WD_IVL_RST = 3'h7;
  localparam int unsigned WD_W       = 21;
  localparam logic [4:0]  WD_EXP_OFS = 5'h6;
  localparam logic [2:0]  DIS_WINDOW = 3'h4;

  // ****************************************************************
  // Reset timing and reset state
  // ****************************************************************
  localparam int unsigned PIN_HOLD        = 12;
  localparam int unsigned CLK_PERIOD_NS   = 4;
  localparam int unsigned MON_TIMEOUT_MS  = 100;
  localparam int unsigned MON_HOLD_CYCLES =
    MON_TIMEOUT_MS * 1000000 / CLK_PERIOD_NS;
  localparam logic [7:0]  PORT_RESET_VAL  = 8'hFF;
  localparam logic [15:0] RESET_VECTOR    = 16'h0000;

  // Terminal count for interval k: 4^(3+k) cycles, minus one.
  function automatic logic [WD_W-1:0] wd_limit(input logic [2:0] k);
    logic [WD_W:0] p;
    p = {{(WD_W){1'b0}}, 1'b1} << (5'({k, 1'b0}) + WD_EXP_OFS);
    return p[WD_W-1:0] - {{(WD_W-1){1'b0}}, 1'b1};
  endfunction : wd_limit

endpackage : rsw_pkg

// [hdl/rsw_stretch.sv]
// Reset stretcher: holds active while triggered and for HOLD cycles after.
// Assumes trigger is synchronous to aclk.
`timescale 1ns/1ps
module rsw_stretch #(
  parameter int unsigned HOLD = 12
) (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic trigger,
  output logic      active
);
  localparam int unsigned CW = $clog2(HOLD + 1);

  logic [CW-1:0] cnt;

  // Reload while triggered, count down once the source lets go.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt <= '0;
    end else if (trigger) begin
      cnt <= CW'(HOLD);
    end else if (cnt != '0) begin
      cnt <= cnt - CW'(1);
    end
  end

  assign active = trigger | (cnt != '0);

endmodule : rsw_stretch

// [hdl/rsw_disarm.sv]
// Watchdog disable-sequence tracker: first byte arms a short window.
// Assumes wr_strobe is a one-cycle pulse per control register write.
`timescale 1ns/1ps
module rsw_disarm (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       clear,
  input  wire logic       wr_strobe,
  input  wire logic [7:0] wr_data,
  output logic            disable_ok
);
  logic [2:0] left;

  // Any other byte or an expired window forgets the first byte.
  always_ff @(posedge aclk) begin
    if (!aresetn || clear) begin
      left <= 3'h0;
    end else if (wr_strobe) begin
      left <= (wr_data == rsw_pkg::WD_DIS1) ? rsw_pkg::DIS_WINDOW : 3'h0;
    end else if (left != 3'h0) begin
      left <= left - 3'h1;
    end
  end

  // Second byte counts only while the window is still open.
  assign disable_ok = wr_strobe && (wr_data == rsw_pkg::WD_DIS2)
                      && (left != 3'h0);

endmodule : rsw_disarm

// [verification/rsw_far.sv]
// Far side model: reset pin pull-up, supply and fault sources.
// Assumes the bench moves pin_pull and flt just after rising edges.
`timescale 1ns/1ps
module rsw_far (
  input  wire logic       rst_pin_oe,
  input  wire logic       pin_pull,
  input  wire logic [3:0] flt,
  output logic            rst_pin_in,
  output logic            supply_low,
  output logic            supply_monitor_en_pin,
  output logic            cmp_plus_above_minus,
  output logic            conversion_start_input,
  output logic            clock_loss_detected,
  output logic            clock_stable
);
  // The pin has a pull-up, so it reads high unless someone sinks it.
  assign rst_pin_in = !(rst_pin_oe || pin_pull);
  // Monitor strapped on, so the power-on bit alone gates it after power-up.
  assign supply_monitor_en_pin = 1'b1;
  assign supply_low = flt[0];
  assign cmp_plus_above_minus = !flt[1];
  assign conversion_start_input = !flt[2];
  assign clock_loss_detected = flt[3];
  assign clock_stable = 1'b1;
endmodule : rsw_far

// [verification/tb.sv]
// Bench for the reset controller and watchdog.
// Assumes rsw_pkg, rsw_top and rsw_far are compiled first.
`timescale 1ns/1ps
module tb;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, pin_pull, supply_low, rst_pin_in;
  logic supply_monitor_en_pin, rst_pin_out, rst_pin_oe, clock_stable;
  logic conversion_start_input, cmp_plus_above_minus, clock_loss_detected;
  logic adc_convstart, sys_reset_n;
  logic [7:0] awaddr, araddr, port_latch_value;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp;
  logic [3:0] flt;
  logic core_halt, port_latch_load, stack_ptr_reload, irq_timer_disable;
  logic osc_lowest_select, fetch_enable;
  logic [15:0] fetch_address;
  wire logic [7:0] st = {core_halt, port_latch_load, stack_ptr_reload,
    irq_timer_disable, osc_lowest_select, fetch_enable, rst_pin_out, 1'b0};
  wire logic [7:0] fa = fetch_address[15:8] | fetch_address[7:0];
  wire logic [7:0] cv = 8'(adc_convstart & ~conversion_start_input);
  logic [7:0] en [4] = '{8'h02, 8'h22, 8'h42, 8'h06};
  logic [7:0] fl [4] = '{8'h02, 8'h20, 8'h40, 8'h04};
  int failures = 0, total_checks = 0, n;
  rsw_top #(.MON_HOLD_CYCLES(20)) uut (.aclk, .aresetn, .awaddr, .awvalid,
    .awready, .wdata, .wstrb(4'hF), .wvalid, .wready, .bresp, .bvalid,
    .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .supply_low, .supply_monitor_en_pin, .rst_pin_in, .rst_pin_out,
    .rst_pin_oe, .conversion_start_input, .cmp_plus_above_minus,
    .clock_loss_detected, .clock_stable, .adc_convstart, .sys_reset_n,
    .core_halt, .port_latch_load, .port_latch_value, .fetch_enable,
    .stack_ptr_reload, .irq_timer_disable, .osc_lowest_select,
    .fetch_address);
  rsw_far far (.rst_pin_oe, .pin_pull, .flt, .rst_pin_in, .supply_low,
    .supply_monitor_en_pin, .cmp_plus_above_minus, .clock_stable,
    .conversion_start_input, .clock_loss_detected);
  task automatic summarize();
    if (failures == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : summarize
  task automatic chk(input string nm, input logic [7:0] e, g);
    total_checks++;
    if (g !== e) begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // Counts cycles while the system reset holds lvl, ends after an edge.
  task automatic cnt(input logic lvl);
    n = 0;
    do begin
      @(negedge aclk);
      n++;
    end while (sys_reset_n === lvl && n < 300);
    @(posedge aclk);
    chk("wait", 8'h01, {7'h0, n < 300});
  endtask : cnt
  // Both bus tasks start just after a rising edge and end just after one.
  // Ready stays high between calls so no edge sees it dropped and raised.
  task automatic wr(input logic [7:0] a, d);
    logic [2:0] h;
    logic [1:0] b, er;
    er = (a == rsw_pkg::ADDR_CAUSE || a == rsw_pkg::ADDR_WDOG) ?
      rsw_pkg::RESP_OKAY : rsw_pkg::RESP_SLVERR;
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(negedge aclk);
      h = {awvalid & awready, wvalid & wready, bvalid};
      b = bresp;
      @(posedge aclk);
      if (h[2]) awvalid <= 1'b0;
      if (h[1]) wvalid <= 1'b0;
    end while (!h[0]);
    chk("bresp", {6'h0, er}, {6'h0, b});
  endtask : wr
  task automatic rd(input string nm, input logic [7:0] a, e);
    logic [1:0] h, r, er;
    logic [7:0] v;
    er = (a == rsw_pkg::ADDR_CAUSE || a == rsw_pkg::ADDR_WDOG) ?
      rsw_pkg::RESP_OKAY : rsw_pkg::RESP_SLVERR;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(negedge aclk);
      h = {arvalid & arready, rvalid};
      v = rdata[7:0];
      r = rresp;
      @(posedge aclk);
      if (h[1]) arvalid <= 1'b0;
    end while (!h[0]);
    chk("rresp", {6'h0, er}, {6'h0, r});
    if (er === rsw_pkg::RESP_OKAY) chk(nm, e, v);
  endtask : rd
  // Free-running clock at 250 MHz.
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  // Cuts a hang short; the tests need a few hundred cycles.
  initial begin
    #100000;
    failures++;
    summarize();
  end
  // Main sequence of register calls and reset episodes.
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, pin_pull} = '0;
    {awaddr, araddr, wdata, flt} = '0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    cnt(1'b0);
    chk("port_latch", 8'hFF, port_latch_value);
    // Registered outputs are looked at between edges, where they settle.
    @(negedge aclk);
    chk("run_state", 8'h04, st);
    chk("fetch_addr", 8'h00, fa);
    @(posedge aclk);
    rd("cause", rsw_pkg::ADDR_CAUSE, 8'h02);
    rd("wdog", rsw_pkg::ADDR_WDOG, 8'h17);
    rd("unmapped", 8'h08, 8'h00);
    wr(8'h08, 8'h00);
    wr(rsw_pkg::ADDR_WDOG, rsw_pkg::WD_DIS1);
    wr(rsw_pkg::ADDR_WDOG, rsw_pkg::WD_DIS2);
    rd("wdog_off", rsw_pkg::ADDR_WDOG, 8'h07);
    wr(rsw_pkg::ADDR_WDOG, rsw_pkg::WD_KICK);
    rd("wdog_on", rsw_pkg::ADDR_WDOG, 8'h17);
    wr(rsw_pkg::ADDR_WDOG, rsw_pkg::WD_DIS1);
    repeat (4) @(posedge aclk);
    wr(rsw_pkg::ADDR_WDOG, rsw_pkg::WD_DIS2);
    rd("wdog_late", rsw_pkg::ADDR_WDOG, 8'h17);
    wr(rsw_pkg::ADDR_WDOG, rsw_pkg::WD_LOCK);
    wr(rsw_pkg::ADDR_WDOG, rsw_pkg::WD_DIS1);
    wr(rsw_pkg::ADDR_WDOG, rsw_pkg::WD_DIS2);
    rd("wdog_lock", rsw_pkg::ADDR_WDOG, 8'h17);
    wr(rsw_pkg::ADDR_WDOG, 8'h00);
    wr(rsw_pkg::ADDR_WDOG, 8'hA3);
    rd("interval", rsw_pkg::ADDR_WDOG, 8'h10);
    wr(rsw_pkg::ADDR_WDOG, rsw_pkg::WD_KICK);
    cnt(1'b1);
    chk("wdog_gap", 8'h01, 8'(n > 57 && n < 71));
    cnt(1'b0);
    rd("cause_wdog", rsw_pkg::ADDR_CAUSE, 8'h08);
    pin_pull <= 1'b1;
    repeat (3) @(posedge aclk);
    pin_pull <= 1'b0;
    cnt(1'b0);
    chk("pin_hold", 8'h01, 8'(n > 11 && n < 17));
    rd("cause_pin", rsw_pkg::ADDR_CAUSE, 8'h01);
    for (int i = 0; i < 4; i++) begin
      wr(rsw_pkg::ADDR_CAUSE, en[i]);
      flt <= 4'h1 << i;
      repeat (3) @(negedge aclk);
      chk("pin_oe", 8'(i == 0), 8'(rst_pin_oe));
      chk("rst_state", 8'hF8, st);
      chk("adc", 8'(i == 2), cv);
      @(posedge aclk);
      flt <= 4'h0;
      cnt(1'b0);
      rd("cause_src", rsw_pkg::ADDR_CAUSE, fl[i]);
    end
    summarize();
  end
endmodule : tb
